//--- rtl/srd_top.v
// Shift register serdes: receive, parallel-to-serial and two-wire exchange
// Function
// - Each clock edge moves chain one stage
// - Four stages, each visible as output
// - One common reset clears all stages
// - One common selector chooses parallel load for all stages
// - Load enable also clocks loaded stages
// - Dedicated reset input clears receive chain
// - Long low on data starts oscillator
// - Internal clock gives exactly stage-count pulses
// - Common load/shift selects parallel or previous
// - Two shared lines, data and clock
// - Transmit enable gates clock and enables
// - Pulse counter ends transmission after count
// - Receive on far clock, send on own
// - Transmit clock from free running counter
// - Transmit-first variant always sends first
// - Receive-first variant sends only after receiving
// - External clock counter sets transmit enable
// - Received word readable by host port
// - Pattern store rewritable between transmissions
// - One-shot high from start until count
`include "srd_regs.vh"
module srd_top #(
  parameter N          = `SRD_STAGES,
  parameter START_CYC  = `SRD_START_LOW_CYC,
  parameter HALF_CYC   = `SRD_TXCLK_HALF_CYC,
  parameter FIFO_DEPTH = `SRD_FIFO_DEPTH
) (
  input  wire         i_mclk,
  input  wire         i_rst_n,
  input  wire [1:0]   i_mode,
  input  wire         i_stage_clear_n,
  input  wire         i_ser_clk,
  input  wire         i_ser_data,
  input  wire         i_load_en,
  input  wire [N-1:0] i_par_data,
  input  wire         i_start,
  input  wire         i_pat_wr,
  input  wire [N-1:0] i_pat_data,
  input  wire         i_word_ready,
  output reg  [N-1:0] o_par_out,
  output reg          o_word_valid,
  output reg  [N-1:0] o_word,
  output reg          o_pat_ready,
  output reg          o_busy,
  output reg          o_ser_out,
  output reg          o_data_out,
  output reg          o_data_oe_n,
  output reg          o_clk_out,
  output reg          o_clk_oe_n
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // Serial clock, serial data, load, start and stage clear pins pass two flops before use; edges are one-cycle pulses
  // Edge outputs that nothing reads are left open
  wire clk_rise;                   // Clock line rose
  wire dat_lvl;                    // Settled data line
  wire ld_lvl,  ld_rise;           // Load strobe level and rise
  wire st_lvl,  st_rise,  st_fall; // Start pin level and edges
  wire clr_lvl;                    // Settled stage clear, low clears
  srd_sync u_sclk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_ser_clk),
                   .o_level(), .o_rise(clk_rise), .o_fall());
  srd_sync u_sdat (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_ser_data),
                   .o_level(dat_lvl), .o_rise(), .o_fall());
  srd_sync u_load (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_load_en),
                   .o_level(ld_lvl), .o_rise(ld_rise), .o_fall());
  srd_sync u_strt (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_start),
                   .o_level(st_lvl), .o_rise(st_rise), .o_fall(st_fall));
  srd_sync u_sclr (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_async(i_stage_clear_n),
                   .o_level(clr_lvl), .o_rise(), .o_fall());

  ////////////////////////////////////////////////////////////////////////
  // State
  localparam [1:0] ST_IDLE = 2'h0; // Waiting
  localparam [1:0] ST_RX   = 2'h1; // Receiving on far clock
  localparam [1:0] ST_TX   = 2'h2; // Sending on own clock
  localparam [1:0] ST_BUR  = 2'h3; // Internal receive burst

  reg [N-1:0]  chain_q;     // Shift chain
  reg [N-1:0]  pat_q;       // Pattern store
  reg [1:0]    st_q;        // Sequencer state
  reg          tx_en_q;     // Transmit enable flip-flop
  reg [3:0]    rx_cnt_q;    // Far clock edges counted
  reg [3:0]    tx_cnt_q;    // Own clock pulses counted
  reg [7:0]    div_q;       // Free running clock divider
  reg          tclk_q;      // Internal transmit clock
  reg [11:0]   low_q;       // Data-low timer
  reg          done_q;      // Exchange finished for this start
  reg          push_q;      // Word to buffer
  reg [N-1:0]  word_q;      // Finished word, kept apart from the chain
  // A receive-first reload overwrites the chain on the very edge that
  // completes the word, so the buffer takes its copy from word_q instead

  wire tclk_rise = (div_q == HALF_CYC[7:0] - 8'h01) & ~tclk_q;
  wire tclk_fall = (div_q == HALF_CYC[7:0] - 8'h01) &  tclk_q;
  wire chain_clr = ~clr_lvl | ~i_rst_n;
  wire fifo_rdy;
  wire [N-1:0] fifo_dout;
  wire fifo_vld;

  // Shift one step: previous stage feeds next, serial in at stage 0
  function [N-1:0] srd_shift;
    input [N-1:0] cur;
    input         sin;
    begin
      srd_shift = {cur[N-2:0], sin};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Internal clock: free running reset counter, no enable
  // Runs while idle too, so a transmit-first send starts on a known phase
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_q  <= 8'h00;
      tclk_q <= 1'b0;
    end else if (div_q == HALF_CYC[7:0] - 8'h01) begin
      div_q  <= 8'h00;
      tclk_q <= ~tclk_q;
    end else begin
      div_q  <= div_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start detector: data line held low long enough
  // Saturates at the limit; only internal-clock mode looks at it
  always @(posedge i_mclk) begin
    if (!i_rst_n)
      low_q <= 12'h000;
    else if (dat_lvl || st_q != ST_IDLE)
      low_q <= 12'h000;
    else if (low_q != START_CYC[11:0])
      low_q <= low_q + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Chain, sequencer and transmit enable
  // Clear wins over everything; a stage clear without reset keeps the pattern store
  always @(posedge i_mclk) begin
    if (chain_clr) begin
      chain_q  <= `SRD_CLR_VAL;
      st_q     <= ST_IDLE;
      tx_en_q  <= 1'b0;
      rx_cnt_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      done_q   <= 1'b0;
      push_q   <= 1'b0;
      word_q   <= `SRD_CLR_VAL;
      if (!i_rst_n)
        pat_q <= `SRD_CLR_VAL;
    end else begin
      push_q <= 1'b0;
      // Pattern rewrite only while not sending
      if (i_pat_wr && !tx_en_q)
        pat_q <= i_pat_data;
      // Load strobe doubles as the commit clock
      if (ld_rise && !tx_en_q)
        chain_q <= ld_lvl ? i_par_data : chain_q;
      case (st_q)
        ST_IDLE: begin
          if (st_fall)
            done_q <= 1'b0;
          case (i_mode)
            `SRD_MODE_EXT: begin
              // Far side owns the clock here; every rise takes one bit
              if (clk_rise)
                chain_q <= srd_shift(chain_q, dat_lvl);
              if (clk_rise && rx_cnt_q == N[3:0] - 4'h1) begin
                rx_cnt_q <= 4'h0;
                push_q   <= 1'b1;
                word_q   <= srd_shift(chain_q, dat_lvl);
              end else if (clk_rise) begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
              end
            end
            `SRD_MODE_INT: begin
              if (low_q == START_CYC[11:0] || st_rise) begin
                st_q     <= ST_BUR;
                tx_cnt_q <= 4'h0;
              end
            end
            `SRD_MODE_TXF: begin
              // Start on a fall so data settles half a period before the first rise
              if (st_lvl && !done_q && tclk_fall) begin
                tx_en_q  <= 1'b1;
                chain_q  <= pat_q;
                st_q     <= ST_TX;
                tx_cnt_q <= 4'h0;
              end
            end
            default: begin
              if (st_lvl && !done_q) begin
                st_q     <= ST_RX;
                rx_cnt_q <= 4'h0;
              end
            end
          endcase
        end
        ST_BUR: begin
          // Burst of exactly N internal pulses
          // Samples the data line on each internal rise
          if (tclk_rise) begin
            chain_q  <= srd_shift(chain_q, dat_lvl);
            if (tx_cnt_q == N[3:0] - 4'h1) begin
              st_q   <= ST_IDLE;
              push_q <= 1'b1;
              word_q <= srd_shift(chain_q, dat_lvl);
            end
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
        ST_TX: begin
          // Own clock drives pins, chain shifts out from last stage
          // Pulses are counted on rises; the enable drops on the fall after
          // the last rise, so the final high phase reaches the pin whole
          if (tclk_rise)
            tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tclk_fall && tx_cnt_q == N[3:0]) begin
            tx_en_q <= 1'b0;
            if (i_mode == `SRD_MODE_TXF) begin
              st_q     <= ST_RX;
              rx_cnt_q <= 4'h0;
            end else begin
              st_q   <= ST_IDLE;
              done_q <= 1'b1;
            end
          end else if (tclk_fall && tx_cnt_q != 4'h0) begin
            chain_q <= srd_shift(chain_q, 1'b0);
          end
        end
        default: begin
          // Receive on far clock edges
          // Counts far clock rises; the Nth one completes the word
          if (clk_rise) begin
            chain_q  <= srd_shift(chain_q, dat_lvl);
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == N[3:0] - 4'h1) begin
              push_q <= 1'b1;
              word_q <= srd_shift(chain_q, dat_lvl);
              if (i_mode == `SRD_MODE_RXF) begin
                st_q <= ST_TX;
                tx_en_q <= 1'b1;
                tx_cnt_q <= 4'h0;
              end else begin
                st_q   <= ST_IDLE;
                done_q <= 1'b1;
              end
            end
          end
        end
      endcase
      // Reload pattern for the answer; the received word is already in word_q
      if (st_q == ST_RX && clk_rise && rx_cnt_q == N[3:0] - 4'h1 && i_mode == `SRD_MODE_RXF)
        chain_q <= pat_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received words buffered toward the reader
  // A full buffer drops the new word; o_pat_ready low shows the stall
  srd_fifo #(.WIDTH(N), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_data  (word_q),
    .i_valid (push_q),
    .o_ready (fifo_rdy),
    .o_data  (fifo_dout),
    .o_valid (fifo_vld),
    .i_ready (i_word_ready & o_word_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Clock pin stays low until the first counted rise, so a send that
  // begins inside a high phase never shows a short pulse
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_par_out    <= `SRD_CLR_VAL;
      o_word_valid <= 1'b0;
      o_word       <= `SRD_CLR_VAL;
      o_pat_ready  <= 1'b0;
      o_busy       <= 1'b0;
      o_ser_out    <= 1'b0;
      o_data_out   <= 1'b0;
      o_data_oe_n  <= 1'b1;
      o_clk_out    <= 1'b0;
      o_clk_oe_n   <= 1'b1;
    end else begin
      o_par_out    <= chain_q;
      o_word_valid <= fifo_vld & ~(i_word_ready & o_word_valid);
      o_word       <= fifo_dout;
      o_pat_ready  <= ~tx_en_q & fifo_rdy;
      o_busy       <= (st_q != ST_IDLE);
      o_ser_out    <= chain_q[N-1];
      o_data_out   <= chain_q[N-1];
      o_data_oe_n  <= ~tx_en_q;
      o_clk_out    <= tclk_q & tx_en_q & (tx_cnt_q != 4'h0);
      o_clk_oe_n   <= ~tx_en_q;
    end
  end
endmodule

//--- inc/srd_regs.vh
// Constants for the shift register serdes block
`ifndef SRD_REGS_VH
`define SRD_REGS_VH
`define SRD_STAGES        4
`define SRD_CLR_VAL       4'h0
`define SRD_FIFO_DEPTH    8
`define SRD_START_LOW_NS  200
`define SRD_START_LOW_CYC ((`SRD_START_LOW_NS + 3) / 4)
`define SRD_TXCLK_HALF_NS 40
`define SRD_TXCLK_HALF_CYC (`SRD_TXCLK_HALF_NS / 4)
`define SRD_MODE_EXT      2'h0
`define SRD_MODE_INT      2'h1
`define SRD_MODE_TXF      2'h2
`define SRD_MODE_RXF      2'h3
`endif

//--- rtl/srd_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
module srd_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_mclk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Storage
  reg [AW-1:0]    wr_q;              // Write index
  reg [AW-1:0]    rd_q;              // Read index
  reg [AW:0]      cnt_q;             // Fill level
  wire push;
  wire pop;
  assign o_ready = (cnt_q != DEPTH[AW:0]);
  assign o_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  // Index and level update
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= i_data;
        wr_q        <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

//--- rtl/srd_sync.v
// Two flip-flop synchroniser with rise detect on the clean side
module srd_sync (
  input  wire i_mclk,
  input  wire i_rst_n,
  input  wire i_async,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_q; // First stage, read only by the second
  reg sync_q; // Settled level
  reg prev_q; // Delayed settled level for edges
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
  assign o_fall  = ~sync_q & prev_q;
endmodule

//--- tb/srd_top_properties.sv
// Port-level checks for the serdes block
module srd_chk #(
  parameter N        = 4,
  parameter HALF_CYC = 10
) (
  input wire logic         i_mclk,
  input wire logic         i_rst_n,
  input wire logic [1:0]   i_mode,
  input wire logic         i_stage_clear_n,
  input wire logic         i_word_ready,
  input wire logic [N-1:0] o_par_out,
  input wire logic         o_word_valid,
  input wire logic [N-1:0] o_word,
  input wire logic         o_pat_ready,
  input wire logic         o_busy,
  input wire logic         o_ser_out,
  input wire logic         o_data_out,
  input wire logic         o_data_oe_n,
  input wire logic         o_clk_out,
  input wire logic         o_clk_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Longest legal drive window: receive-first may wait a whole period for its first rise
  localparam int LIM = 2 * HALF_CYC * (N + 1) + 4;
  logic [15:0] oe_cnt_q;  // Cycles with pins driven
  always @(posedge i_mclk) begin
    oe_cnt_q <= (!i_rst_n || o_data_oe_n) ? 16'h0000 : oe_cnt_q + 16'h0001;
  end
  chk_reset_idle: assert property (disable iff (1'b0) !i_rst_n |=> o_data_oe_n && o_clk_oe_n &&
    o_par_out == '0 && !o_word_valid) else $error("outputs not idle in reset");
  chk_oe_together: assert property (o_data_oe_n == o_clk_oe_n) else $error("enables differ");
  chk_clk_gated: assert property (o_clk_oe_n && $past(o_clk_oe_n) |-> !o_clk_out)
    else $error("clock out while released");
  chk_tx_window: assert property (oe_cnt_q <= LIM) else $error("drive window too long");
  chk_rx_quiet: assert property (!o_data_oe_n |-> i_mode[1]) else $error("drive in receive mode");
  chk_busy_tx: assert property (!o_data_oe_n |-> o_busy) else $error("idle while driving");
  chk_pat_locked: assert property (!o_data_oe_n && $past(!o_data_oe_n) |-> !o_pat_ready)
    else $error("pattern writable in send");
  chk_word_hold: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
    else $error("word lost before pop");
  chk_ser_mirror: assert property (o_ser_out == o_data_out) else $error("serial outputs differ");
  chk_clear_chain: assert property (!i_stage_clear_n [*6] |-> o_par_out == '0)
    else $error("chain not cleared");
endmodule
bind srd_top srd_chk #(.N(N), .HALF_CYC(HALF_CYC)) u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_mode(i_mode), .i_stage_clear_n(i_stage_clear_n), .i_word_ready(i_word_ready), .o_par_out(o_par_out),
  .o_word_valid(o_word_valid), .o_word(o_word), .o_pat_ready(o_pat_ready), .o_busy(o_busy),
  .o_ser_out(o_ser_out), .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n), .o_clk_out(o_clk_out),
  .o_clk_oe_n(o_clk_oe_n));

//--- tb/srd_far.sv
// Far-side IC model: drives the link lines, captures the device's frames
module srd_far (
  input wire logic i_mclk,
  input wire logic i_clk_line,
  input wire logic i_data_line,
  input wire logic i_oe_n,
  output logic     o_clk,
  output logic     o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cap;   // Bits captured from the device
  logic [2:0] ncap;  // Clock pulses seen while device drives
  initial begin
    o_clk = 0;
    o_data = 0;
    cap = 0;
    ncap = 0;
  end
  // One bit: clock low then high, 160 ns; data held past the fall is not kept
  task bit1(input logic b);
    o_data = b;
    #80 o_clk = 1;
    #80 o_clk = 0;
    o_data = ~b;
  endtask
  // Whole word, first bit is the MSB; clock idles low between frames
  task send(input logic [3:0] w);
    @(posedge i_mclk);
    #1;
    for (int i = 3; i >= 0; i--) bit1(w[i]);
  endtask
  // Sample on the device's clock while it owns the pins
  always @(posedge i_clk_line) begin
    if (!i_oe_n) begin
      cap <= {cap[2:0], i_data_line};
      ncap <= ncap + 3'd1;
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the serdes block
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t %s", $time, m); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk = 0, i_rst_n = 0, i_stage_clear_n = 1, i_load_en = 0, i_start = 0, i_pat_wr = 0, i_word_ready = 0;
  logic [1:0] i_mode = 0;
  logic [3:0] i_par_data = 0, i_pat_data = 0, o_par_out, o_word;
  logic o_word_valid, o_pat_ready, o_busy, o_ser_out, o_data_out, o_data_oe_n, o_clk_out, o_clk_oe_n;
  logic far_clk, far_data;
  // Shared lines: whoever enables its driver owns the wire
  wire clk_line = !o_clk_oe_n ? o_clk_out : far_clk;
  wire data_line = !o_data_oe_n ? o_data_out : far_data;
  int miscompares = 0, n_compared = 0, k;
  logic [7:0] seed = 8'h1B;
  logic [3:0] w[8];
  srd_top DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode(i_mode), .i_stage_clear_n(i_stage_clear_n),
    .i_ser_clk(clk_line), .i_ser_data(data_line), .i_load_en(i_load_en), .i_par_data(i_par_data),
    .i_start(i_start), .i_pat_wr(i_pat_wr), .i_pat_data(i_pat_data), .i_word_ready(i_word_ready),
    .o_par_out(o_par_out), .o_word_valid(o_word_valid), .o_word(o_word), .o_pat_ready(o_pat_ready),
    .o_busy(o_busy), .o_ser_out(o_ser_out), .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n),
    .o_clk_out(o_clk_out), .o_clk_oe_n(o_clk_oe_n));
  srd_far far (.i_mclk(i_mclk), .i_clk_line(clk_line), .i_data_line(data_line), .i_oe_n(o_data_oe_n),
    .o_clk(far_clk), .o_data(far_data));
  always #2 i_mclk = ~i_mclk;
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Inputs always change 1 ns after the edge
  task step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task report_and_stop;
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Wait for a word at the head, compare it, pop it
  task pop(input logic [3:0] e);
    for (k = 0; k < 500 && o_word_valid !== 1'b1; k++) step(1);
    `CHK(k < 500, 1'b1, "no word in time")
    `CHK(o_word, e, "received word")
    i_word_ready = 1;
    step(1);
    i_word_ready = 0;
    step(3);
  endtask
  // One exchange; mode 2 speaks first, mode 3 answers
  task xchg(input logic [1:0] m, input logic [3:0] p, input logic [3:0] r);
    i_mode = m;
    i_pat_data = p;
    i_pat_wr = 1;
    step(1);
    i_pat_wr = 0;
    far.ncap = 0;
    step(3);
    i_start = 1;
    if (m == 2'h3) begin
      step(100);
      `CHK(o_data_oe_n, 1'b1, "spoke before far side")
      far.send(r);
    end
    for (k = 0; k < 2000 && o_data_oe_n !== 1'b0; k++) step(1);
    for (k = 0; k < 2000 && o_data_oe_n !== 1'b1; k++) step(1);
    `CHK(k < 2000, 1'b1, "send did not end")
    `CHK(far.cap, p, "sent pattern")
    `CHK(far.ncap, 3'd4, "sent pulse count")
    if (m == 2'h2) far.send(r);
    pop(r);
    i_start = 0;
    step(10);
  endtask
  initial begin
    step(2);
    i_rst_n = 1;
    step(3);
    `CHK(o_data_oe_n, 1'b1, "idle enable")
    `CHK(o_par_out, 4'h0, "chain after reset")
    // Fill the buffer with random words while the reader stalls
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      w[i] = seed[3:0];
      far.send(w[i]);
      step(4);
      `CHK(o_par_out, w[i], "parallel copy")
    end
    `CHK(o_pat_ready, 1'b0, "full buffer")
    far.send(4'hA);
    step(4);
    for (int i = 0; i < 8; i++) pop(w[i]);
    `CHK(o_word_valid, 1'b0, "drained buffer")
    i_par_data = 4'h9;
    i_load_en = 1;
    step(6);
    i_load_en = 0;
    step(4);
    `CHK(o_par_out, 4'h9, "parallel load")
    `CHK(o_ser_out, 1'b1, "serial bit from last stage")
    far.bit1(1'b0);
    step(6);
    `CHK(o_par_out, 4'h2, "shift after load")
    i_stage_clear_n = 0;
    step(8);
    `CHK(o_par_out, 4'h0, "cleared chain")
    i_stage_clear_n = 1;
    step(4);
    // Internal burst samples a steady high line
    i_mode = 2'h1;
    far.o_data = 1'b1;
    step(4);
    i_start = 1;
    pop(4'hF);
    `CHK(o_busy, 1'b0, "burst stopped")
    i_start = 0;
    step(4);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      xchg({1'b1, seed[0]}, seed[7:4], seed[3:0]);
    end
    report_and_stop();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
